// ===== core/mif_irq_flags.sv
// Interrupt status and enable registers of the metering front end.
// Assumes one-cycle event strobes synchronous to ref_clk and an SFR port
// from the embedded core with single-cycle write and read strobes.

`timescale 1ns/1ps

module mif_irq_flags (
  // Clock, reset and clock enable.
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // Software reset request, one-cycle pulse.
  input  wire logic                 soft_reset,
  // Event strobes from the metering datapath.
  input  wire mif_pkg::mif_events_t events,
  // SFR port from the core.
  input  wire mif_pkg::mif_sfr_req_t sfr_req,
  output logic                      sfr_hit,
  output logic [7:0]                sfr_rdata,
  // Combined metering interrupt toward the core.
  output logic                      irq_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the write and read paths.

  // Returns a one-hot select: bits 2..0 enable groups, bits 5..3 status groups.
  function automatic logic [5:0] decode_sfr(input logic [7:0] addr);
    logic [5:0] sel;
    sel = 6'h00;
    case (addr)
      mif_pkg::ADDR_IRQ_ENABLE_LOW:  sel = 6'h01;
      mif_pkg::ADDR_IRQ_ENABLE_MID:  sel = 6'h02;
      mif_pkg::ADDR_IRQ_ENABLE_HIGH: sel = 6'h04;
      mif_pkg::ADDR_IRQ_STATUS_LOW:  sel = 6'h08;
      mif_pkg::ADDR_IRQ_STATUS_MID:  sel = 6'h10;
      mif_pkg::ADDR_IRQ_STATUS_HIGH: sel = 6'h20;
      default:                       sel = 6'h00;
    endcase
    return sel;
  endfunction

  logic [5:0]      sel;
  logic [2:0][7:0] enable_q;
  logic [2:0][7:0] status_q;
  logic [2:0][7:0] enable_mask;
  logic [2:0][7:0] flag_mask;
  logic [2:0][7:0] status_rst;
  logic [2:0][7:0] event_vec;
  logic [2:0][7:0] next_status;
  logic [2:0][7:0] active_hits;
  logic            summary;

  // Decode is purely combinational so the core's SFR mux can steer early.
  assign sel     = decode_sfr(sfr_req.addr);
  assign sfr_hit = |sel;

  // Per-group constants packed for the generate loop below.
  assign enable_mask = {mif_pkg::ENABLE_MASK_HIGH, mif_pkg::ENABLE_MASK_MID,
                        mif_pkg::ENABLE_MASK_LOW};
  assign flag_mask   = {mif_pkg::FLAG_MASK_HIGH, mif_pkg::FLAG_MASK_MID,
                        mif_pkg::FLAG_MASK_LOW};
  assign status_rst  = {mif_pkg::STATUS_RESET_HIGH, mif_pkg::STATUS_RESET_MID,
                        mif_pkg::STATUS_RESET_LOW};
  assign event_vec   = {events.high, events.mid, events.low};

  ////////////////////////////////////////////////////////////////////////////
  // Enable registers. Reserved bits never store, so they read as zero.

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= {mif_pkg::ENABLE_RESET, mif_pkg::ENABLE_RESET, mif_pkg::ENABLE_RESET};
    end else if (clk_en) begin
      if (soft_reset) begin
        enable_q <= {mif_pkg::ENABLE_RESET, mif_pkg::ENABLE_RESET, mif_pkg::ENABLE_RESET};
      end else if (sfr_req.wr) begin
        for (int g = 0; g < mif_pkg::GRP_COUNT; g++) begin
          if (sel[g]) begin
            enable_q[g] <= sfr_req.wdata & enable_mask[g];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags. A write of zero clears a flag, a write of one leaves it
  // alone, so the core may clear one flag without racing the others. An event
  // in the same cycle as its clear wins, so no event is lost to a clear.

  genvar gi;
  generate
    for (gi = 0; gi < mif_pkg::GRP_COUNT; gi++) begin : g_status
      logic [7:0] clr;
      // Clear mask from a write to this group's status address.
      assign clr = (sfr_req.wr && sel[gi + 3]) ? ~sfr_req.wdata : 8'h00;
      // Set has priority over clear; unimplemented bits stay zero.
      assign next_status[gi] = ((status_q[gi] & ~clr) | event_vec[gi]) & flag_mask[gi];
      // Flags that currently contribute to the pending interrupt.
      assign active_hits[gi] = status_q[gi] & enable_q[gi] & enable_mask[gi];
    end
  endgenerate

  // Event bit placement follows the status layout one to one, so every flag
  // is caught by the same loop: fault, sign and no-load flags in the low
  // group, calibration pulses, overflow and half-full in the middle, and the
  // waveform, peak, cycle and zero-crossing flags in the high group.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= {mif_pkg::STATUS_RESET_HIGH, mif_pkg::STATUS_RESET_MID,
                   mif_pkg::STATUS_RESET_LOW};
    end else if (clk_en) begin
      if (soft_reset) begin
        status_q <= status_rst;
      end else begin
        status_q <= next_status;
        // Same update covers waveform, peak, cycle and zero-crossing flags.
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Summary flag. It is derived, not stored, so it falls in the same cycle that the
  // last enabled flag is cleared or its enable is removed.

  assign summary = |{active_hits[mif_pkg::GRP_HIGH], active_hits[mif_pkg::GRP_MID],
                     active_hits[mif_pkg::GRP_LOW]};

  // Registered copy toward the core keeps the interrupt line glitch free.
  // A software reset drops it at the next enabled edge, without waiting for the summary.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pending <= 1'b0;
    end else if (clk_en) begin
      if (soft_reset) begin
        irq_pending <= 1'b0;
      end else begin
        irq_pending <= summary;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path. Data is registered one cycle after the read strobe and holds
  // until the next read or a soft reset; an unmapped address returns zero.

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= mif_pkg::READ_IDLE;
    end else if (clk_en) begin
      if (soft_reset) begin
        sfr_rdata <= mif_pkg::READ_IDLE;
      end else if (sfr_req.rd) begin
        case (sel)
          6'h01:   sfr_rdata <= enable_q[mif_pkg::GRP_LOW];
          6'h02:   sfr_rdata <= enable_q[mif_pkg::GRP_MID];
          6'h04:   sfr_rdata <= enable_q[mif_pkg::GRP_HIGH];
          6'h08: begin
            sfr_rdata <= status_q[mif_pkg::GRP_LOW];
            sfr_rdata[mif_pkg::BIT_SUMMARY_IRQ_FLAG] <= summary;
          end
          6'h10:   sfr_rdata <= status_q[mif_pkg::GRP_MID];
          6'h20:   sfr_rdata <= status_q[mif_pkg::GRP_HIGH];
          default: sfr_rdata <= mif_pkg::READ_IDLE;
        endcase
      end
    end
  end

endmodule

// ===== core/mif_pkg.sv
// Constants and carrier types for the metering interrupt flag block.
// Assumes the embedded core reaches the block through its 8-bit SFR port.
package mif_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Special-function register addresses.
  localparam logic [7:0] ADDR_IRQ_ENABLE_LOW  = 8'hd9;
  localparam logic [7:0] ADDR_IRQ_ENABLE_MID  = 8'hda;
  localparam logic [7:0] ADDR_IRQ_ENABLE_HIGH = 8'hdb;
  localparam logic [7:0] ADDR_IRQ_STATUS_LOW  = 8'hdc;
  localparam logic [7:0] ADDR_IRQ_STATUS_MID  = 8'hdd;
  localparam logic [7:0] ADDR_IRQ_STATUS_HIGH = 8'hde;

  ////////////////////////////////////////////////////////////////////////////
  // Group indices: low, middle and high registers of each kind.
  localparam int unsigned GRP_LOW   = 0;
  localparam int unsigned GRP_MID   = 1;
  localparam int unsigned GRP_HIGH  = 2;
  localparam int unsigned GRP_COUNT = 3;

  // Low status field positions.
  localparam int unsigned BIT_SUMMARY_IRQ_FLAG      = 7;
  localparam int unsigned BIT_FAULT_MODE_CHANGE     = 5;
  localparam int unsigned BIT_REACTIVE_SIGN_CHANGE  = 4;
  localparam int unsigned BIT_ACTIVE_SIGN_CHANGE    = 3;
  localparam int unsigned BIT_APPARENT_NO_LOAD      = 2;
  localparam int unsigned BIT_REACTIVE_NO_LOAD      = 1;
  localparam int unsigned BIT_ACTIVE_NO_LOAD        = 0;

  // Middle status field positions.
  localparam int unsigned BIT_CAL_PULSE_TWO            = 7;
  localparam int unsigned BIT_CAL_PULSE_ONE            = 6;
  localparam int unsigned BIT_APPARENT_ENERGY_OVERFLOW = 5;
  localparam int unsigned BIT_REACTIVE_ENERGY_OVERFLOW = 4;
  localparam int unsigned BIT_ACTIVE_ENERGY_OVERFLOW   = 3;
  localparam int unsigned BIT_APPARENT_ENERGY_HALF     = 2;
  localparam int unsigned BIT_REACTIVE_ENERGY_HALF     = 1;
  localparam int unsigned BIT_ACTIVE_ENERGY_HALF       = 0;

  // High status field positions.
  localparam int unsigned BIT_RESET_DONE            = 7;
  localparam int unsigned BIT_WAVEFORM_SAMPLE_READY = 5;
  localparam int unsigned BIT_CURRENT_PEAK_HIT      = 4;
  localparam int unsigned BIT_VOLTAGE_PEAK_HIT      = 3;
  localparam int unsigned BIT_LINE_CYCLE_DONE       = 2;
  localparam int unsigned BIT_ZERO_CROSS_TIMEOUT    = 1;
  localparam int unsigned BIT_ZERO_CROSS_SEEN       = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Implemented bits per group; everything else reads as zero, except bit 7 of the low status register, which reads the summary.
  localparam logic [7:0] ENABLE_MASK_LOW  = 8'h3f;
  localparam logic [7:0] ENABLE_MASK_MID  = 8'hff;
  localparam logic [7:0] ENABLE_MASK_HIGH = 8'h3f;
  localparam logic [7:0] FLAG_MASK_LOW    = 8'h3f;
  localparam logic [7:0] FLAG_MASK_MID    = 8'hff;
  localparam logic [7:0] FLAG_MASK_HIGH   = 8'hbf;

  // Reset values. The end-of-reset flag comes up set.
  localparam logic [7:0] ENABLE_RESET      = 8'h00;
  localparam logic [7:0] STATUS_RESET_LOW  = 8'h00;
  localparam logic [7:0] STATUS_RESET_MID  = 8'h00;
  localparam logic [7:0] STATUS_RESET_HIGH = 8'h80;
  localparam logic [7:0] READ_IDLE         = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle event strobes from the metering datapath, laid out as the
  // status registers; bits at unimplemented positions are ignored.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] mid;
    logic [7:0] low;
  } mif_events_t;

  // SFR request from the core.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mif_sfr_req_t;

endpackage

// ===== verif/mif_chk_asserts.sv
// Checker for the metering interrupt flag block.
// Assumes one clock, ref_clk, and the asynchronous active-low rst_n.
`timescale 1ns/1ps
module mif_chk (
  // Clock and controls.
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire logic                  soft_reset,
  // Stimulus seen at the block.
  input wire mif_pkg::mif_events_t  events,
  input wire mif_pkg::mif_sfr_req_t sfr_req,
  // Block answers.
  input wire logic                  sfr_hit,
  input wire logic [7:0]            sfr_rdata,
  input wire logic                  irq_pending
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // A read taken at this edge with no write or soft reset beside it.
  sequence s_rd(logic [7:0] a);
    clk_en && !soft_reset && sfr_req.rd && !sfr_req.wr && sfr_req.addr == a;
  endsequence
  // An event strobe, then the read of its status register two edges later.
  sequence s_ev_rd(logic [7:0] ev, logic [7:0] a);
    (clk_en && !soft_reset && ev != 8'h00) ##2 s_rd(a);
  endsequence
  property p_low;
    s_ev_rd(events.low & 8'h3f, 8'hdc) |=>
      (sfr_rdata & $past(events.low, 3) & 8'h3f) == ($past(events.low, 3) & 8'h3f);
  endproperty
  a_low: assert property (p_low) else $error("low flag missing");
  property p_mid;
    s_ev_rd(events.mid, 8'hdd) |=> (sfr_rdata & $past(events.mid, 3)) == $past(events.mid, 3);
  endproperty
  a_mid: assert property (p_mid) else $error("mid flag missing");
  property p_high;
    s_ev_rd(events.high & 8'h3f, 8'hde) |=>
      (sfr_rdata & $past(events.high, 3) & 8'h3f) == ($past(events.high, 3) & 8'h3f);
  endproperty
  a_high: assert property (p_high) else $error("high flag missing");
  // The pending line copies the summary bit taken by the same read.
  property p_sum;
    s_rd(8'hdc) |=> sfr_rdata[7] == irq_pending;
  endproperty
  a_sum: assert property (p_sum) else $error("summary and pending differ");
  property p_en_rsv;
    clk_en && sfr_req.rd && (sfr_req.addr == 8'hd9 || sfr_req.addr == 8'hdb) |=>
      sfr_rdata[7:6] == 2'b00;
  endproperty
  a_en_rsv: assert property (p_en_rsv) else $error("reserved enable bits set");
  property p_unmapped;
    clk_en && sfr_req.rd && !sfr_hit |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hit;
    sfr_hit == (sfr_req.addr >= 8'hd9 && sfr_req.addr <= 8'hde);
  endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  property p_soft;
    clk_en && soft_reset |=> !irq_pending && sfr_rdata == 8'h00;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset left state");
  // A low clock enable must freeze every registered output.
  property p_freeze;
    !clk_en |=> $stable(sfr_rdata) && $stable(irq_pending);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule
bind mif_irq_flags mif_chk mif_chk_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
  .soft_reset(soft_reset), .events(events), .sfr_req(sfr_req), .sfr_hit(sfr_hit),
  .sfr_rdata(sfr_rdata), .irq_pending(irq_pending));

// ===== verif/mif_cpu.sv
// Model of the embedded core reaching the flag block through its SFR port.
// Assumes requests start at a falling edge and are taken at the next rise.
`timescale 1ns/1ps
module mif_cpu (
  // Clock.
  input wire logic                  ref_clk,
  // Request out, read data back.
  output mif_pkg::mif_sfr_req_t     sfr_req,
  input wire logic [7:0]            sfr_rdata
);
  initial sfr_req = '0;
  // Holds one request across one rising edge, then releases it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge ref_clk);
    sfr_req = '0;
  endtask
  // Read data is taken after the edge that took the request.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    sfr_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge ref_clk);
    d = sfr_rdata;
    sfr_req = '0;
  endtask
  // Service: write zero only to the handled flags, ones elsewhere.
  task automatic ack(input logic [7:0] a, input logic [7:0] b);
    wr(a, ~b);
  endtask
endmodule

// ===== verif/tb.sv
// Self-checking bench for the metering interrupt flag block.
// Assumes the core model drives the SFR port; events come from here.
`timescale 1ns/1ps
module tb;
  logic                  ref_clk;
  logic                  rst_n;
  logic                  soft_reset;
  logic                  clk_en;
  logic                  sfr_hit;
  logic                  irq_pending;
  logic [7:0]            sfr_rdata;
  logic [7:0]            v;
  mif_pkg::mif_events_t  events;
  mif_pkg::mif_sfr_req_t sfr_req;
  int                    n_mismatch = 0;
  int                    samples_checked = 0;

  mif_irq_flags mif_irq_flags_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .soft_reset(soft_reset), .events(events), .sfr_req(sfr_req), .sfr_hit(sfr_hit),
    .sfr_rdata(sfr_rdata), .irq_pending(irq_pending));
  mif_cpu mif_cpu_inst (.ref_clk(ref_clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One-cycle strobe on group g, launched at a falling edge.
  task automatic pulse(input int g, input logic [7:0] b);
    mif_pkg::mif_events_t e;
    e = '0;
    e[g*8 +: 8] = b;
    @(negedge ref_clk);
    events = e;
    @(negedge ref_clk);
    events = '0;
  endtask
  task automatic t_reset;
    logic [7:0] exp [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    for (int i = 0; i < 7; i++) begin
      mif_cpu_inst.rd(8'hd9 + 8'(i), v);
      chk("reset value", v, exp[i]);
    end
    $display("test reset done");
  endtask
  // Every flag that has an enable bit, in turn: set, pend, service, drop.
  task automatic t_flags;
    logic [7:0] m [3] = '{8'h3f, 8'hff, 8'h3f};
    logic [7:0] b;
    mif_cpu_inst.ack(8'hde, 8'h80);
    for (int g = 0; g < 3; g++) begin
      mif_cpu_inst.wr(8'hd9 + 8'(g), 8'hff);
      mif_cpu_inst.rd(8'hd9 + 8'(g), v);
      chk("enable", v, m[g]);
      for (int i = 0; i < 8; i++) begin
        if (m[g][i]) begin
          b = 8'h01 << i;
          pulse(g, b);
          mif_cpu_inst.rd(8'hdc + 8'(g), v);
          chk("flag", v, b | ((g == 0) ? 8'h80 : 8'h00));
          chk("pending", {7'h00, irq_pending}, 8'h01);
          mif_cpu_inst.ack(8'hdc + 8'(g), b);
          mif_cpu_inst.rd(8'hdc + 8'(g), v);
          chk("cleared", v, 8'h00);
          chk("idle", {7'h00, irq_pending}, 8'h00);
        end
      end
    end
    $display("test flags done");
  endtask
  // A masked flag sets but stays silent until its enable arrives.
  task automatic t_mask;
    mif_cpu_inst.wr(8'hd9, 8'h00);
    pulse(0, 8'h01);
    mif_cpu_inst.rd(8'hdc, v);
    chk("masked flag", v, 8'h01);
    chk("masked pending", {7'h00, irq_pending}, 8'h00);
    mif_cpu_inst.wr(8'hd9, 8'h01);
    mif_cpu_inst.rd(8'hdc, v);
    chk("late enable", v, 8'h81);
    chk("late pending", {7'h00, irq_pending}, 8'h01);
    mif_cpu_inst.wr(8'hd9, 8'h00);
    mif_cpu_inst.rd(8'hdc, v);
    chk("disabled", v, 8'h01);
    chk("disabled pending", {7'h00, irq_pending}, 8'h00);
    mif_cpu_inst.ack(8'hdc, 8'h01);
    $display("test mask done");
  endtask
  // A software reset restores enables and raises the end-of-reset flag.
  task automatic t_soft;
    @(negedge ref_clk);
    soft_reset = 1'b1;
    @(negedge ref_clk);
    soft_reset = 1'b0;
    mif_cpu_inst.rd(8'hda, v);
    chk("soft enable", v, 8'h00);
    mif_cpu_inst.rd(8'hde, v);
    chk("soft reset flag", v, 8'h80);
    // An event while the clock enable is low must leave no trace.
    @(negedge ref_clk);
    clk_en = 1'b0;
    pulse(0, 8'h01);
    clk_en = 1'b1;
    mif_cpu_inst.rd(8'hdc, v);
    chk("frozen event", v, 8'h00);
    $display("test soft done");
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    summarize;
  end
  initial begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    clk_en = 1'b1;
    events = '0;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset;
    t_flags;
    t_mask;
    t_soft;
    summarize;
  end
endmodule
